// *** ftj_pkg.sv ***
// constants and carrier types for the focus start and track jump sequencer
// assumes one 100 MHz system clock; all servo inputs already synchronous
// How it works
// - on laser start, discharge the sweep first, then drive sweep high
// - falling focus zero-cross during sweep drops sweep, closing focus loop
// - sweep with no focus_ok and no zero-cross since laser on means no disc present
// - indications seen but no lock: retry, up to three focus sweeps in all
// - mirror indicator is inverse of rf envelope, judges on or off track
// - one-track jump: accel pulse, decel from zero-cross edge for 233 us
// - mirror inhibit high during one-track jump, hiding the 17 ms brake
// - jumps of 4, 16 and 32 tracks exist beside the single track jump
// - 16-track jump accelerates for 9 track periods, counted by zero-cross
// - then decelerates 7 track periods and brakes for 17 ms
// - in brake, latch mirror on each zero-cross edge to gate tracking loop
package ftj_pkg;
  localparam int CLK_MHZ = 100;
  localparam int DECEL_1T_US = 233;
  localparam int DECEL_1T_CYC = DECEL_1T_US * CLK_MHZ;
  localparam int BRAKE_MS = 17;
  localparam int BRAKE_CYC = BRAKE_MS * 1000 * CLK_MHZ;
  localparam int DISCHARGE_US = 100;
  localparam int DISCHARGE_CYC = DISCHARGE_US * CLK_MHZ;
  localparam int SWEEP_MS = 500;
  localparam int SWEEP_CYC = SWEEP_MS * 1000 * CLK_MHZ;
  localparam int LOCK_WAIT_MS = 10;
  localparam int LOCK_WAIT_CYC = LOCK_WAIT_MS * 1000 * CLK_MHZ;
  localparam logic [1:0] SWEEP_TRIES = 2'h3;
  localparam int TIMER_W = 26;
  localparam logic [5:0] ACC_4 = 6'h02;
  localparam logic [5:0] DEC_4 = 6'h02;
  localparam logic [5:0] ACC_16 = 6'h09;
  localparam logic [5:0] DEC_16 = 6'h07;
  localparam logic [5:0] ACC_32 = 6'h11;
  localparam logic [5:0] DEC_32 = 6'h0F;

  typedef enum logic [1:0] {
    FTJ_JUMP_1 = 2'h0,
    FTJ_JUMP_4 = 2'h1,
    FTJ_JUMP_16 = 2'h2,
    FTJ_JUMP_32 = 2'h3
  } ftj_jump_t;

  typedef struct packed {
    logic start;
    ftj_jump_t size;
    logic reverse;
  } ftj_jump_cmd_t;

  typedef struct packed {
    logic sweep_discharge;
    logic focus_sweep;
    logic focus_locked;
    logic no_disc;
    logic focus_fail;
    logic busy;
  } ftj_focus_stat_t;

  typedef struct packed {
    logic jump_accel_pulse;
    logic jump_decel_pulse;
    logic mirror_inhibit;
    logic tracking_off;
    logic brake;
    logic busy;
  } ftj_track_out_t;
endpackage

// *** ftj_focus_start.sv ***
// focus start sequencer: discharge, upward sweep, lock judgement, retries
// assumes focus_zero_cross and focus_ok are synchronous to clk_sys
`timescale 1ns/100ps
`default_nettype none
module ftj_focus_start #(
  parameter int DISCHARGE_CYCLES = ftj_pkg::DISCHARGE_CYC,
  parameter int SWEEP_CYCLES = ftj_pkg::SWEEP_CYC,
  parameter int LOCK_CYCLES = ftj_pkg::LOCK_WAIT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic laser_on,
  input wire logic focus_zero_cross,
  input wire logic focus_ok,
  output ftj_pkg::ftj_focus_stat_t stat
);
  import ftj_pkg::*;

  typedef enum logic [2:0] {
    FS_IDLE = 3'b000,
    FS_DISCH = 3'b001,
    FS_SWEEP = 3'b011,
    FS_LOCKW = 3'b010,
    FS_LOCKED = 3'b110,
    FS_NODISC = 3'b111,
    FS_FAIL = 3'b101
  } ftj_fs_state_t;

  ftj_fs_state_t state_q;
  logic [TIMER_W-1:0] timer_q;
  logic [1:0] tries_q;
  logic seen_q;
  logic focus_zc_q;
  logic focus_zc_fall;

  assign focus_zc_fall = focus_zc_q & ~focus_zero_cross;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      focus_zc_q <= 1'b1;
    end else begin
      focus_zc_q <= focus_zero_cross;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= FS_IDLE;
      timer_q <= '0;
      tries_q <= 2'h0;
      seen_q <= 1'b0;
    end else if (!laser_on) begin
      state_q <= FS_IDLE;
      timer_q <= '0;
      tries_q <= 2'h0;
      seen_q <= 1'b0;
    end else begin
      case (state_q)
        FS_IDLE: begin
          state_q <= FS_DISCH;
          timer_q <= TIMER_W'(DISCHARGE_CYCLES - 1);
        end
        FS_DISCH: begin
          if (timer_q == '0) begin
            state_q <= FS_SWEEP;
            timer_q <= TIMER_W'(SWEEP_CYCLES - 1);
          end else begin
            timer_q <= timer_q - 1'b1;
          end
        end
        FS_SWEEP: begin
          if (focus_ok) begin
            seen_q <= 1'b1;
          end
          if (focus_zc_fall) begin
            state_q <= FS_LOCKW;
            seen_q <= 1'b1;
            timer_q <= TIMER_W'(LOCK_CYCLES - 1);
          end else if (timer_q == '0) begin
            if (!seen_q && !focus_ok) begin
              state_q <= FS_NODISC;
            end else begin
              state_q <= FS_LOCKW;
              timer_q <= TIMER_W'(LOCK_CYCLES - 1);
            end
          end else begin
            timer_q <= timer_q - 1'b1;
          end
        end
        FS_LOCKW: begin
          if (focus_ok) begin
            state_q <= FS_LOCKED;
          end else if (timer_q == '0) begin
            // indications were seen, so retry rather than call it no disc
            if (tries_q == SWEEP_TRIES - 2'h1) begin
              state_q <= FS_FAIL;
            end else begin
              tries_q <= tries_q + 2'h1;
              state_q <= FS_DISCH;
              timer_q <= TIMER_W'(DISCHARGE_CYCLES - 1);
            end
          end else begin
            timer_q <= timer_q - 1'b1;
          end
        end
        FS_LOCKED: begin
          if (!focus_ok) begin
            state_q <= FS_LOCKW;
            timer_q <= TIMER_W'(LOCK_CYCLES - 1);
          end
        end
        FS_NODISC, FS_FAIL: begin
          state_q <= state_q;
        end
        default: begin
          state_q <= FS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    stat.sweep_discharge = (state_q == FS_DISCH);
    stat.focus_sweep = (state_q == FS_SWEEP);
    stat.focus_locked = (state_q == FS_LOCKED);
    stat.no_disc = (state_q == FS_NODISC);
    stat.focus_fail = (state_q == FS_FAIL);
    stat.busy = (state_q == FS_DISCH) || (state_q == FS_SWEEP) ||
                (state_q == FS_LOCKW);
  end
endmodule // ftj_focus_start
`default_nettype wire

// *** ftj_sequencer.sv ***
// top of the servo sequencer: focus start plus 1/4/16/32 track jumps
// assumes host pulses jump command start for one cycle; inputs synchronous
`timescale 1ns/100ps
`default_nettype none
module ftj_sequencer #(
  parameter int DISCHARGE_CYCLES = ftj_pkg::DISCHARGE_CYC,
  parameter int SWEEP_CYCLES = ftj_pkg::SWEEP_CYC,
  parameter int LOCK_CYCLES = ftj_pkg::LOCK_WAIT_CYC,
  parameter int DECEL_1T_CYCLES = ftj_pkg::DECEL_1T_CYC,
  parameter int BRAKE_CYCLES = ftj_pkg::BRAKE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic laser_on,
  input wire logic focus_zero_cross,
  input wire logic focus_ok,
  input wire logic rf_envelope,
  input wire logic track_zero_cross,
  input wire ftj_pkg::ftj_jump_cmd_t jump_cmd,
  output ftj_pkg::ftj_focus_stat_t focus_stat,
  output logic mirror_indicator,
  output logic jump_reverse,
  output ftj_pkg::ftj_track_out_t track_out
);
  import ftj_pkg::*;

  typedef enum logic [2:0] {
    TJ_IDLE = 3'b000,
    TJ_ACCEL = 3'b001,
    TJ_DECEL = 3'b011,
    TJ_BRAKE = 3'b010
  } ftj_tj_state_t;

  function automatic logic [5:0] accel_count(input ftj_jump_t s);
    case (s)
      FTJ_JUMP_4: accel_count = ACC_4;
      FTJ_JUMP_16: accel_count = ACC_16;
      FTJ_JUMP_32: accel_count = ACC_32;
      default: accel_count = 6'h01;
    endcase
  endfunction

  function automatic logic [5:0] decel_count(input ftj_jump_t s);
    case (s)
      FTJ_JUMP_4: decel_count = DEC_4;
      FTJ_JUMP_16: decel_count = DEC_16;
      FTJ_JUMP_32: decel_count = DEC_32;
      default: decel_count = 6'h00;
    endcase
  endfunction

  ftj_focus_start #(
    .DISCHARGE_CYCLES(DISCHARGE_CYCLES),
    .SWEEP_CYCLES(SWEEP_CYCLES),
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_focus (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .laser_on(laser_on),
    .focus_zero_cross(focus_zero_cross),
    .focus_ok(focus_ok),
    .stat(focus_stat)
  );

  ftj_tj_state_t state_q;
  logic [TIMER_W-1:0] timer_q;
  logic [5:0] tracks_q;
  logic single_q;
  logic rev_q;
  logic mirror_q;
  logic toff_q;
  logic track_zc_q;
  logic track_zc_edge;
  ftj_jump_t jump_size_q;

  assign track_zc_edge = track_zc_q ^ track_zero_cross;

  // mirror follows the inverse of the rf envelope, registered
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mirror_q <= 1'b0;
      track_zc_q <= 1'b0;
    end else begin
      mirror_q <= ~rf_envelope;
      track_zc_q <= track_zero_cross;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= TJ_IDLE;
      timer_q <= '0;
      tracks_q <= 6'h00;
      single_q <= 1'b0;
      rev_q <= 1'b0;
    end else begin
      case (state_q)
        TJ_IDLE: begin
          if (jump_cmd.start) begin
            state_q <= TJ_ACCEL;
            single_q <= (jump_cmd.size == FTJ_JUMP_1);
            tracks_q <= accel_count(jump_cmd.size);
            rev_q <= jump_cmd.reverse;
          end
        end
        TJ_ACCEL: begin
          if (track_zc_edge) begin
            if (single_q) begin
              state_q <= TJ_DECEL;
              timer_q <= TIMER_W'(DECEL_1T_CYCLES - 1);
            end else if (tracks_q == 6'h01) begin
              state_q <= TJ_DECEL;
              tracks_q <= decel_count(
                single_q ? FTJ_JUMP_1 : jump_size_q);
            end else begin
              tracks_q <= tracks_q - 6'h01;
            end
          end
        end
        TJ_DECEL: begin
          if (single_q) begin
            if (timer_q == '0) begin
              state_q <= TJ_BRAKE;
              timer_q <= TIMER_W'(BRAKE_CYCLES - 1);
            end else begin
              timer_q <= timer_q - 1'b1;
            end
          end else if (track_zc_edge) begin
            if (tracks_q == 6'h01) begin
              state_q <= TJ_BRAKE;
              timer_q <= TIMER_W'(BRAKE_CYCLES - 1);
            end else begin
              tracks_q <= tracks_q - 6'h01;
            end
          end
        end
        TJ_BRAKE: begin
          // commands are not looked at until this phase ends
          if (timer_q == '0) begin
            state_q <= TJ_IDLE;
          end else begin
            timer_q <= timer_q - 1'b1;
          end
        end
        default: begin
          state_q <= TJ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      jump_size_q <= FTJ_JUMP_1;
    end else if (state_q == TJ_IDLE && jump_cmd.start) begin
      jump_size_q <= jump_cmd.size;
    end
  end

  // brake: mirror sampled at each zero-cross edge gates the tracking loop
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      toff_q <= 1'b0;
    end else if (state_q == TJ_BRAKE && !single_q) begin
      if (track_zc_edge) begin
        toff_q <= mirror_q;
      end
    end else begin
      toff_q <= 1'b0;
    end
  end

  assign mirror_indicator = mirror_q;
  assign jump_reverse = rev_q;

  always_comb begin
    track_out.jump_accel_pulse = (state_q == TJ_ACCEL);
    track_out.jump_decel_pulse = (state_q == TJ_DECEL);
    track_out.mirror_inhibit = single_q && (state_q != TJ_IDLE);
    track_out.tracking_off = toff_q;
    track_out.brake = (state_q == TJ_BRAKE) && !single_q;
    track_out.busy = (state_q != TJ_IDLE);
  end
endmodule // ftj_sequencer
`default_nettype wire

// *** ftj_checker.sv ***
// port assertions for the servo sequencer, bound to ftj_sequencer
// assumes the shortened counts set by the testbench
`timescale 1ns/100ps
`default_nettype none
module ftj_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic focus_zero_cross,
  input wire logic rf_envelope,
  input wire ftj_pkg::ftj_jump_cmd_t jump_cmd,
  input wire ftj_pkg::ftj_focus_stat_t focus_stat,
  input wire logic mirror_indicator,
  input wire logic jump_reverse,
  input wire ftj_pkg::ftj_track_out_t track_out
);
  import ftj_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_discharge_then_sweep: assert property (
    $rose(focus_stat.sweep_discharge)
    |-> !focus_stat.focus_sweep ##[1:8] focus_stat.focus_sweep)
    else $error("sweep did not follow discharge");
  a_zc_ends_sweep: assert property (
    focus_stat.focus_sweep && $fell(focus_zero_cross)
    |-> ##[0:2] !focus_stat.focus_sweep) else $error("sweep kept on");
  a_no_disc_idle: assert property ($rose(focus_stat.no_disc)
    |-> $past(focus_stat.focus_sweep) && !focus_stat.focus_locked)
    else $error("no disc without a sweep");
  a_mirror_inverse: assert property ($past(rst_b)
    |-> mirror_indicator == !$past(rf_envelope)) else $error("mirror wrong");
  a_jump_start: assert property (jump_cmd.start && !track_out.busy
    |=> track_out.jump_accel_pulse && track_out.busy
    && jump_reverse == $past(jump_cmd.reverse)) else $error("jump not begun");
  a_inhibit_single: assert property (
    jump_cmd.start && !track_out.busy && jump_cmd.size == FTJ_JUMP_1
    |=> track_out.mirror_inhibit) else $error("inhibit missing");
  a_decel_single: assert property (
    $rose(track_out.jump_decel_pulse) && track_out.mirror_inhibit
    |-> track_out.jump_decel_pulse[*8]) else $error("decel cut short");
  a_no_brake_single: assert property (track_out.mirror_inhibit
    |-> !track_out.brake && !track_out.tracking_off)
    else $error("brake in single jump");
  a_brake_hold: assert property ($rose(track_out.brake)
    |-> track_out.brake[*8]) else $error("brake cut short");
  a_accel_only_new: assert property (
    $rose(track_out.jump_accel_pulse) |-> $rose(track_out.busy))
    else $error("jump taken while busy");
  a_trk_off_brake: assert property ($rose(track_out.tracking_off)
    |-> track_out.brake || $past(track_out.brake))
    else $error("loop off early");
endmodule // ftj_checker
bind ftj_sequencer ftj_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .focus_zero_cross(focus_zero_cross), .rf_envelope(rf_envelope),
  .jump_cmd(jump_cmd), .focus_stat(focus_stat),
  .mirror_indicator(mirror_indicator), .jump_reverse(jump_reverse),
  .track_out(track_out));
`default_nettype wire

// *** ftj_disc_model.sv ***
// pickup and disc model: zero-cross edges and focus indications
// assumes the sequencer outputs of one clk_sys domain
`timescale 1ns/100ps
`default_nettype none
module ftj_disc_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic disc_present,
  input wire logic lock_en,
  input wire ftj_pkg::ftj_focus_stat_t focus_stat,
  input wire ftj_pkg::ftj_track_out_t track_out,
  output logic track_zero_cross,
  output logic focus_zero_cross,
  output logic focus_ok
);
  import ftj_pkg::*;
  logic [1:0] ph_q;
  logic [3:0] sw_q;
  // tracks pass every third cycle while the actuator moves or brakes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ph_q <= 2'h0;
      track_zero_cross <= 1'b0;
    end else if (track_out.busy) begin
      ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      if (ph_q == 2'h2) track_zero_cross <= !track_zero_cross;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sw_q <= 4'h0;
      focus_zero_cross <= 1'b1;
      focus_ok <= 1'b0;
    end else if (!focus_stat.focus_sweep) begin
      sw_q <= 4'h0;
      // focus is lost once the sequencer gives up or the laser goes off
      if (!focus_stat.busy && !focus_stat.focus_locked) begin
        focus_ok <= 1'b0;
      end
    end else begin
      sw_q <= (sw_q == 4'hF) ? sw_q : sw_q + 4'h1;
      if (sw_q == 4'h0) focus_zero_cross <= 1'b1;
      if (disc_present && sw_q == 4'h5) begin
        focus_zero_cross <= 1'b0;
        focus_ok <= 1'b1;
      end else if (!lock_en) begin
        focus_ok <= 1'b0;
      end
    end
  end
endmodule // ftj_disc_model
`default_nettype wire

// *** test_ftj_sequencer.sv ***
// self-checking bench: focus start outcomes, mirror, all jump sizes
// assumes ftj_pkg and the disc model; counts shortened by parameters
`timescale 1ns/100ps
`default_nettype none
module test_ftj_sequencer;
  import ftj_pkg::*;
  localparam int D1 = 10;
  localparam int BRK = 30;
  logic clk_sys = 1'b0, rst_b = 1'b0, laser_on = 1'b0, rf_envelope = 1'b0;
  logic disc_present = 1'b0, lock_en = 1'b0;
  logic track_zero_cross, focus_zero_cross, focus_ok, mirror_indicator;
  logic jump_reverse, track_zc_q, sweep_q;
  ftj_jump_cmd_t jump_cmd = '0;
  ftj_focus_stat_t focus_stat;
  ftj_track_out_t track_out;
  int miscompares = 0, cmp_count = 0;
  int acc_e = 0, dec_e = 0, dec_c = 0, brk_c = 0, inh_c = 0, sweeps = 0;
  int toff_c = 0;
  ftj_sequencer #(.DISCHARGE_CYCLES(4), .SWEEP_CYCLES(50), .LOCK_CYCLES(20),
    .DECEL_1T_CYCLES(D1), .BRAKE_CYCLES(BRK)) dut (.clk_sys(clk_sys),
    .rst_b(rst_b), .laser_on(laser_on), .focus_zero_cross(focus_zero_cross),
    .focus_ok(focus_ok), .rf_envelope(rf_envelope), .jump_cmd(jump_cmd),
    .track_zero_cross(track_zero_cross), .focus_stat(focus_stat),
    .mirror_indicator(mirror_indicator), .jump_reverse(jump_reverse),
    .track_out(track_out));
  ftj_disc_model u_disc (.clk_sys(clk_sys), .rst_b(rst_b),
    .disc_present(disc_present), .lock_en(lock_en), .focus_stat(focus_stat),
    .track_out(track_out), .track_zero_cross(track_zero_cross),
    .focus_zero_cross(focus_zero_cross), .focus_ok(focus_ok));
  initial begin
    forever #5 clk_sys = !clk_sys;
  end
  // tb-side tallies, taken where values are settled before the edge
  always @(posedge clk_sys) begin
    track_zc_q <= track_zero_cross;
    sweep_q <= focus_stat.focus_sweep;
    if (track_zero_cross !== track_zc_q && track_out.jump_accel_pulse) acc_e++;
    if (track_zero_cross !== track_zc_q && track_out.jump_decel_pulse) dec_e++;
    if (track_out.tracking_off === 1'b1) toff_c++;
    if (track_out.jump_decel_pulse === 1'b1) dec_c++;
    if (track_out.brake === 1'b1) brk_c++;
    if (track_out.mirror_inhibit === 1'b1) inh_c++;
    if (focus_stat.focus_sweep === 1'b1 && sweep_q === 1'b0) sweeps++;
  end
  task automatic chk_b(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      miscompares++;
      $display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
    end
  endtask
  task automatic t_focus(input logic dp, input logic le, input int n);
    int s0;
    s0 = sweeps;
    @(posedge clk_sys);
    disc_present <= dp;
    lock_en <= le;
    laser_on <= 1'b1;
    for (int i = 0; i < 600; i++) begin
      @(posedge clk_sys);
      #1;
      if ((focus_stat.focus_locked | focus_stat.no_disc
          | focus_stat.focus_fail) === 1'b1) break;
    end
    chk_b(focus_stat.focus_locked, dp & le);
    chk_b(focus_stat.no_disc, !dp);
    chk_b(focus_stat.focus_fail, dp & !le);
    chk_n(sweeps - s0, n);
    chk_b(focus_stat.busy, 1'b0);
    @(posedge clk_sys);
    laser_on <= 1'b0;
    repeat (4) @(posedge clk_sys);
    $display("focus test done, disc %b lock %b", dp, le);
  endtask
  task automatic t_mirror();
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_sys);
      rf_envelope <= v[0];
      repeat (2) @(posedge clk_sys);
      #1;
      chk_b(mirror_indicator, !v[0]);
    end
    $display("mirror test done");
  endtask
  task automatic t_jump(input ftj_jump_t sz, input logic rev, input int na,
      input int nd, input int nb);
    int a0, d0, c0, b0, i0, t0;
    a0 = acc_e;
    d0 = dec_e;
    c0 = dec_c;
    b0 = brk_c;
    i0 = inh_c;
    t0 = toff_c;
    @(posedge clk_sys);
    // rf low keeps the mirror high, so brake must switch the loop off
    rf_envelope <= 1'b0;
    jump_cmd <= {1'b1, sz, rev};
    @(posedge clk_sys);
    jump_cmd <= {1'b0, sz, rev};
    repeat (4) @(posedge clk_sys);
    jump_cmd <= {1'b1, FTJ_JUMP_32, !rev};
    @(posedge clk_sys);
    jump_cmd <= '0;
    #1;
    chk_b(jump_reverse, rev);
    for (int i = 0; i < 800 && track_out.busy !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    repeat (3) @(posedge clk_sys);
    #1;
    chk_b(track_out.busy, 1'b0);
    chk_n(acc_e - a0, na);
    chk_n((nb == 0) ? dec_c - c0 : dec_e - d0, nd);
    chk_n(brk_c - b0, nb);
    chk_b(inh_c > i0, nb == 0);
    chk_b(toff_c > t0, nb != 0);
    chk_b(track_out.tracking_off, 1'b0);
    $display("jump test done, size %0d", sz);
  endtask
  task automatic close_out();
    $display("tests %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_focus(1'b1, 1'b1, 1);
    t_focus(1'b0, 1'b0, 1);
    t_focus(1'b1, 1'b0, SWEEP_TRIES);
    t_mirror();
    t_jump(FTJ_JUMP_1, 1'b1, 1, D1, 0);
    t_jump(FTJ_JUMP_4, 1'b0, ACC_4, DEC_4, BRK);
    t_jump(FTJ_JUMP_16, 1'b1, ACC_16, DEC_16, BRK);
    t_jump(FTJ_JUMP_32, 1'b0, ACC_32, DEC_32, BRK);
    close_out();
  end
endmodule // test_ftj_sequencer
`default_nettype wire
